// ===== core/bit_logic_branch_exec.sv
// Execution unit for bit set, bit test, status word and branch instructions.
//
// How it works
// - status clear ANDs word with inverted low half of mask
// - status set ORs word with low half of mask
// - two-operand OR stores into destination
// - three-operand OR writes source-or-mask to destination
// - bit test ANDs, changes only flags
// - unconditional jumps add sign-extended displacement
// - bit branch taken when bit matches state
// - memory bit read and write stay locked for locked forms only
// - locked forms branch, then set or clear
// - plain modify forms write encoded new state
// - not-equal/equal branch on zero flag
// - signed greater/less-equal use negative or zero
// - signed greater-equal/less use negative flag
// - unsigned greater/less-equal use carry or zero
// - overflow branches use overflow flag
// - carry branches use carry flag
// - conditional branch adds displacement only if true
`default_nettype none
module bit_logic_branch_exec import bit_branch_pkg::*; (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output mem_req_t MEM_REQ,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA
);
	// ----------------------------------------------------------------
	// State and software-visible registers.
	// ----------------------------------------------------------------
	logic [7:0] opcode_q; // Opcode of the current instruction.
	logic mem_mode_q; // Bit operand lies in memory, not in BASE.
	logic [31:0] mask_q; // Mask operand.
	logic [31:0] src_q; // Source operand.
	logic [31:0] dst_q; // Destination operand, written back.
	logic [31:0] pc_q; // Program counter.
	logic [31:0] status_word_q; // Processor status word with flags.
	logic [15:0] disp_q; // Branch displacement.
	logic [31:0] pos_q; // Bit position operand.
	logic [31:0] base_q; // Bit base: register value or address.
	logic taken_q; // Last instruction took its branch.
	exec_state_t state_q; // Sequencer state.
	mem_req_t mem_q; // Memory request driven to the port.
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;

	// ----------------------------------------------------------------
	// Bus decode.
	// ----------------------------------------------------------------
	wire logic access = PSEL & PENABLE;
	wire logic wr_done = access & pready_q & PWRITE;
	wire logic hit_ctrl = PADDR == REG_CTRL;
	wire logic mapped = hit_ctrl | (PADDR == REG_MASK) | (PADDR == REG_SRC)
		| (PADDR == REG_DST) | (PADDR == REG_PC)
		| (PADDR == REG_STATUS_WORD)
		| (PADDR == REG_DISP) | (PADDR == REG_POS) | (PADDR == REG_BASE)
		| (PADDR == REG_STATUS);
	wire logic busy = state_q != ST_IDLE;
	wire logic start = wr_done & hit_ctrl & PWDATA[CTRL_START] & ~busy;
	// Operand registers are frozen while a memory sequence runs.
	wire logic wr_ok = wr_done & ~busy;

	// ----------------------------------------------------------------
	// Instruction decode.
	// ----------------------------------------------------------------
	wire logic [2:0] wid = opcode_q[7:5];
	wire logic [31:0] wmask = (wid == WID_BYTE) ? LOW_BYTE :
		(wid == WID_WORD) ? LOW_HALF : '1;
	wire logic is_or2 = (opcode_q == OP_OR_BYTE_TWO)
		| (opcode_q == OP_OR_WORD_TWO) | (opcode_q == OP_OR_LONG_TWO);
	wire logic is_or3 = (opcode_q == OP_OR_BYTE_THREE)
		| (opcode_q == OP_OR_WORD_THREE) | (opcode_q == OP_OR_LONG_THREE);
	wire logic is_test = (opcode_q == OP_TEST_MASK_BYTE)
		| (opcode_q == OP_TEST_MASK_WORD) | (opcode_q == OP_TEST_MASK_LONG);
	wire logic is_bit = opcode_q[7:3] == OP_BIT_GROUP;
	wire logic is_locked = (opcode_q == OP_LOCKED_ONE_THEN_SET)
		| (opcode_q == OP_LOCKED_ZERO_THEN_CLEAR);
	// Plain test forms leave the bit alone; all others rewrite it.
	wire logic bit_modifies = is_bit & (opcode_q != OP_BRANCH_IF_BIT_ONE)
		& (opcode_q != OP_BRANCH_IF_BIT_ZERO);
	// Odd opcodes test for zero, even ones for one.
	wire logic test_state = ~opcode_q[0];
	// E2, E3 and E6 set the bit; E4, E5 and E7 clear it.
	wire logic new_state = (opcode_q == OP_LOCKED_ONE_THEN_SET)
		| (opcode_q[2:1] == 2'h1);

	// ----------------------------------------------------------------
	// Flag conditions and branch targets.
	// ----------------------------------------------------------------
	wire logic fc = status_word_q[FLAG_C];
	wire logic fv = status_word_q[FLAG_V];
	wire logic fz = status_word_q[FLAG_Z];
	wire logic fn = status_word_q[FLAG_N];
	logic cond_true; // Condition of a flag branch holds.
	logic is_cond; // Opcode is a flag branch.
	wire logic [31:0] disp_b = {{24{disp_q[7]}}, disp_q[7:0]};
	wire logic [31:0] disp_w = {{16{disp_q[15]}}, disp_q};
	wire logic [31:0] pc_byte = pc_q + disp_b;
	wire logic [31:0] pc_word = pc_q + disp_w;

	// Selects the flag test for each conditional branch opcode.
	always_comb begin
		is_cond = 1'b1;
		case (opcode_q)
			OP_BRANCH_NOT_EQUAL: cond_true = ~fz;
			OP_BRANCH_EQUAL: cond_true = fz;
			OP_BRANCH_GREATER_SIGNED: cond_true = ~(fn | fz);
			OP_BRANCH_LESS_EQ_SIGNED: cond_true = fn | fz;
			OP_BRANCH_GREATER_EQ_SIGNED: cond_true = ~fn;
			OP_BRANCH_LESS_SIGNED: cond_true = fn;
			OP_BRANCH_GREATER_UNSIGNED: cond_true = ~(fc | fz);
			OP_BRANCH_LESS_EQ_UNSIGNED: cond_true = fc | fz;
			OP_BRANCH_NO_OVERFLOW: cond_true = ~fv;
			OP_BRANCH_ON_OVERFLOW: cond_true = fv;
			OP_BRANCH_NO_CARRY: cond_true = ~fc;
			OP_BRANCH_ON_CARRY: cond_true = fc;
			default: begin
				cond_true = 1'b0;
				is_cond = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Data paths.
	// ----------------------------------------------------------------
	// OR result sized to the operand width; upper bits keep the old value.
	wire logic [31:0] or_in = is_or3 ? src_q : dst_q;
	wire logic [31:0] or_res = (dst_q & ~wmask)
		| ((mask_q | or_in) & wmask);
	wire logic [31:0] and_res = mask_q & src_q & wmask;
	wire logic and_msb = (wid == WID_BYTE) ? and_res[7] :
		(wid == WID_WORD) ? and_res[15] : and_res[31];
	// Register-held bit operand: position taken modulo the word size.
	wire logic [4:0] reg_idx = pos_q[4:0];
	wire logic reg_bit = base_q[reg_idx];
	logic [31:0] base_mod; // BASE with the tested bit rewritten.
	always_comb begin
		base_mod = base_q;
		base_mod[reg_idx] = new_state;
	end
	// Memory-held bit: byte address and bit index within that byte.
	wire logic [31:0] mem_addr = base_q + {{3{pos_q[31]}}, pos_q[31:3]};
	wire logic [2:0] mem_idx = pos_q[2:0];
	wire logic mem_bit = MEM_RDATA[mem_idx];
	logic [7:0] mem_mod; // Fetched byte with the tested bit rewritten.
	always_comb begin
		mem_mod = MEM_RDATA;
		mem_mod[mem_idx] = new_state;
	end
	wire logic mem_done = MEM_ACK & mem_q.valid;

	// Opcode about to be loaded, used to pick the path at start.
	wire logic is_bit_next = PWDATA[7:3] == OP_BIT_GROUP;
	wire logic is_locked_next = (PWDATA[7:0] == OP_LOCKED_ONE_THEN_SET)
		| (PWDATA[7:0] == OP_LOCKED_ZERO_THEN_CLEAR);
	// Register-only instructions execute the cycle after start.
	logic exec_q;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			exec_q <= 1'b0;
		end else begin
			exec_q <= start & ~(PWDATA[CTRL_BASE_IN_MEM] & is_bit_next);
		end
	end
	wire logic exec_now = exec_q;
	wire logic jump = (opcode_q == OP_JUMP_SHORT_DISP)
		| (opcode_q == OP_JUMP_WORD_DISP);
	wire logic branch_now = jump | (is_cond & cond_true)
		| (is_bit & (reg_bit == test_state));
	wire logic mem_branch = (state_q == ST_READ) & mem_done
		& (mem_bit == test_state);

	// ----------------------------------------------------------------
	// Sequencer: executes on start, runs memory bit operations.
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= ST_IDLE;
			mem_q <= '0;
			taken_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start && PWDATA[CTRL_BASE_IN_MEM] && is_bit_next)
					begin
						// Read with the lock held for locked forms.
						mem_q <= '{valid: 1'b1, write: 1'b0,
							lock: is_locked_next, addr: mem_addr,
							wdata: '0};
						state_q <= ST_READ;
					end
				end
				ST_READ: begin
					if (mem_done) begin
						taken_q <= mem_bit == test_state;
						if (bit_modifies) begin
							// Write back; the lock stays held only for locked forms.
							mem_q.write <= 1'b1;
							mem_q.wdata <= mem_mod;
							state_q <= ST_WRITE;
						end else begin
							mem_q <= '0;
							state_q <= ST_IDLE;
						end
					end
				end
				ST_WRITE: begin
					if (mem_done) begin
						mem_q <= '0; // Lock released only here.
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			if (exec_now) begin
				taken_q <= branch_now;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register file: bus writes and instruction results.
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			opcode_q <= '0;
			mem_mode_q <= 1'b0;
			mask_q <= '0;
			src_q <= '0;
			dst_q <= '0;
			pc_q <= '0;
			status_word_q <= STATUS_WORD_RESET;
			disp_q <= '0;
			pos_q <= '0;
			base_q <= '0;
		end else if (exec_now) begin
			if (opcode_q == OP_STATUS_WORD_CLEAR) begin
				status_word_q <= status_word_q & ~(mask_q & LOW_HALF);
			end else if (opcode_q == OP_STATUS_WORD_SET) begin
				status_word_q <= status_word_q | (mask_q & LOW_HALF);
			end else if (is_or2 || is_or3) begin
				dst_q <= or_res;
			end else if (is_test) begin
				status_word_q[FLAG_Z] <= and_res == '0;
				status_word_q[FLAG_N] <= and_msb;
				status_word_q[FLAG_V] <= 1'b0;
			end
			if (opcode_q == OP_JUMP_WORD_DISP) begin
				pc_q <= pc_word;
			end else if (branch_now) begin
				pc_q <= pc_byte;
			end
			if (bit_modifies) begin
				base_q <= base_mod;
			end
		end else if (mem_branch) begin
			pc_q <= pc_byte;
		end else if (wr_ok) begin
			case (PADDR)
				REG_CTRL: begin
					opcode_q <= PWDATA[7:0];
					mem_mode_q <= PWDATA[CTRL_BASE_IN_MEM];
				end
				REG_MASK: mask_q <= PWDATA;
				REG_SRC: src_q <= PWDATA;
				REG_DST: dst_q <= PWDATA;
				REG_PC: pc_q <= PWDATA;
				REG_STATUS_WORD: status_word_q <= PWDATA;
				REG_DISP: disp_q <= PWDATA[15:0];
				REG_POS: pos_q <= PWDATA;
				REG_BASE: base_q <= PWDATA;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus slave: one wait state, read data captured before completion.
	// ----------------------------------------------------------------
	logic [31:0] rd_mux; // Read data for the addressed register.
	always_comb begin
		case (PADDR)
			REG_CTRL: rd_mux = {22'h0, mem_mode_q, 1'b0, opcode_q};
			REG_MASK: rd_mux = mask_q;
			REG_SRC: rd_mux = src_q;
			REG_DST: rd_mux = dst_q;
			REG_PC: rd_mux = pc_q;
			REG_STATUS_WORD: rd_mux = status_word_q;
			REG_DISP: rd_mux = {16'h0, disp_q};
			REG_POS: rd_mux = pos_q;
			REG_BASE: rd_mux = base_q;
			REG_STATUS: rd_mux = {30'h0, taken_q, busy};
			default: rd_mux = '0;
		endcase
	end

	// Answers every access on its second access cycle.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= access & ~pready_q;
			pslverr_q <= access & ~pready_q & ~mapped;
			if (access && !pready_q && !PWRITE) begin
				prdata_q <= rd_mux;
			end
		end
	end

	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PRDATA = prdata_q;
	assign MEM_REQ = mem_q;
endmodule : bit_logic_branch_exec
`default_nettype wire

// ===== shared/bit_branch_pkg.sv
// Package with opcodes, register map, field positions and types of the unit.
`default_nettype none
package bit_branch_pkg;
	// ----------------------------------------------------------------
	// Opcodes handled by the unit.
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_STATUS_WORD_CLEAR = 8'hB9;
	localparam logic [7:0] OP_STATUS_WORD_SET = 8'hB8;
	localparam logic [7:0] OP_OR_BYTE_TWO = 8'h88;
	localparam logic [7:0] OP_OR_BYTE_THREE = 8'h89;
	localparam logic [7:0] OP_OR_WORD_TWO = 8'hA8;
	localparam logic [7:0] OP_OR_WORD_THREE = 8'hA9;
	localparam logic [7:0] OP_OR_LONG_TWO = 8'hC8;
	localparam logic [7:0] OP_OR_LONG_THREE = 8'hC9;
	localparam logic [7:0] OP_TEST_MASK_BYTE = 8'h93;
	localparam logic [7:0] OP_TEST_MASK_WORD = 8'hB3;
	localparam logic [7:0] OP_TEST_MASK_LONG = 8'hD3;
	localparam logic [7:0] OP_JUMP_SHORT_DISP = 8'h11;
	localparam logic [7:0] OP_JUMP_WORD_DISP = 8'h31;
	localparam logic [7:0] OP_BRANCH_NOT_EQUAL = 8'h12;
	localparam logic [7:0] OP_BRANCH_EQUAL = 8'h13;
	localparam logic [7:0] OP_BRANCH_GREATER_SIGNED = 8'h14;
	localparam logic [7:0] OP_BRANCH_LESS_EQ_SIGNED = 8'h15;
	localparam logic [7:0] OP_BRANCH_GREATER_EQ_SIGNED = 8'h18;
	localparam logic [7:0] OP_BRANCH_LESS_SIGNED = 8'h19;
	localparam logic [7:0] OP_BRANCH_GREATER_UNSIGNED = 8'h1A;
	localparam logic [7:0] OP_BRANCH_LESS_EQ_UNSIGNED = 8'h1B;
	localparam logic [7:0] OP_BRANCH_NO_OVERFLOW = 8'h1C;
	localparam logic [7:0] OP_BRANCH_ON_OVERFLOW = 8'h1D;
	localparam logic [7:0] OP_BRANCH_NO_CARRY = 8'h1E;
	localparam logic [7:0] OP_BRANCH_ON_CARRY = 8'h1F;
	// Bit branches occupy E0 to E7; E6 and E7 are the locked forms.
	localparam logic [4:0] OP_BIT_GROUP = 5'h1C;
	localparam logic [7:0] OP_LOCKED_ONE_THEN_SET = 8'hE6;
	localparam logic [7:0] OP_LOCKED_ZERO_THEN_CLEAR = 8'hE7;
	localparam logic [7:0] OP_BRANCH_IF_BIT_ONE = 8'hE0;
	localparam logic [7:0] OP_BRANCH_IF_BIT_ZERO = 8'hE1;
	// Operand width codes in opcode bits 7:5.
	localparam logic [2:0] WID_BYTE = 3'h4;
	localparam logic [2:0] WID_WORD = 3'h5;
	// ----------------------------------------------------------------
	// Register byte offsets on the bus.
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_SRC = 8'h08;
	localparam logic [7:0] REG_DST = 8'h0C;
	localparam logic [7:0] REG_PC = 8'h10;
	localparam logic [7:0] REG_STATUS_WORD = 8'h14;
	localparam logic [7:0] REG_DISP = 8'h18;
	localparam logic [7:0] REG_POS = 8'h1C;
	localparam logic [7:0] REG_BASE = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	// Control fields and status flag positions.
	localparam int CTRL_START = 8;
	localparam int CTRL_BASE_IN_MEM = 9;
	localparam int FLAG_C = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_N = 3;
	localparam logic [31:0] STATUS_WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] LOW_HALF = 32'h0000_FFFF;
	localparam logic [31:0] LOW_BYTE = 32'h0000_00FF;
	// ----------------------------------------------------------------
	// Types.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic lock;
		logic [31:0] addr;
		logic [7:0] wdata;
	} mem_req_t;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} exec_state_t;
endpackage : bit_branch_pkg
`default_nettype wire

// ===== dv/bit_branch_checker.sv
// Concurrent checks on the ports of the bit, status and branch unit.
`default_nettype none
module bit_branch_checker import bit_branch_pkg::*; (
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire mem_req_t MEM_REQ,
	input wire logic MEM_ACK,
	input wire logic [7:0] MEM_RDATA
);
	// ----------------------------------------------------------------
	// Helper logic.
	// ----------------------------------------------------------------
	logic [7:0] read_byte_q; // Byte returned by the last memory read.
	// Keeps the read byte so the locked write can be compared with it.
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			read_byte_q <= 8'h00;
		end else if (MEM_ACK && MEM_REQ.valid && !MEM_REQ.write) begin
			read_byte_q <= MEM_RDATA;
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// ----------------------------------------------------------------
	// Sequences and assertions.
	// ----------------------------------------------------------------
	sequence apb_setup;
		PSEL && !PENABLE;
	endsequence
	sequence apb_access;
		PSEL && PENABLE;
	endsequence
	sequence locked_read_done;
		MEM_REQ.valid && MEM_REQ.lock && !MEM_REQ.write && MEM_ACK;
	endsequence
	one_wait_a: assert property (apb_setup ##1 apb_access |-> !PREADY ##1 PREADY)
		else $error("ready not in second access cycle");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	ready_access_a: assert property (PREADY |-> apb_access)
		else $error("ready outside an access phase");
	error_decode_a: assert property (PREADY && PADDR[1:0] == 2'b00 |->
		PSLVERR == (PADDR > REG_STATUS))
		else $error("slave error does not match the map");
	error_read_zero_a: assert property (PREADY && PSLVERR && !PWRITE |->
		PRDATA == 32'h0000_0000)
		else $error("unmapped read not zero");
	req_held_a: assert property (MEM_REQ.valid && !MEM_ACK |=> $stable(MEM_REQ))
		else $error("memory request changed before ack");
	locked_pair_a: assert property (locked_read_done |=> MEM_REQ.valid &&
		MEM_REQ.write && MEM_REQ.lock && MEM_REQ.addr == $past(MEM_REQ.addr))
		else $error("locked read not followed by locked write");
	one_bit_write_a: assert property (MEM_REQ.valid && MEM_REQ.write &&
		MEM_REQ.lock |-> $countones(MEM_REQ.wdata ^ read_byte_q) <= 1)
		else $error("locked write changes more than one bit");
	write_ends_a: assert property (MEM_REQ.valid && MEM_REQ.write &&
		MEM_ACK |=> !MEM_REQ.valid)
		else $error("memory request not dropped after write");
endmodule : bit_branch_checker
bind bit_logic_branch_exec bit_branch_checker i_checker (.CLOCK(CLOCK),
	.RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
	.MEM_RDATA(MEM_RDATA));
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the bit, status and branch unit.
`default_nettype none
module testbench import bit_branch_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Signals, memory and counters.
	// ----------------------------------------------------------------
	logic CLOCK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
	logic PWRITE = 1'b0, MEM_ACK = 1'b0;
	logic [7:0] PADDR = 8'h00, MEM_RDATA = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY, PSLVERR;
	mem_req_t MEM_REQ;
	logic [7:0] mem [256]; // Byte memory behind the unit.
	logic [31:0] r [8]; // Mask, source, dest, pc, status, disp, pos, base.
	int errors = 0, n_compared = 0, cyc = 0, dly = 0;
	localparam logic [7:0] OPS [27] = '{8'hB9, 8'hB8, 8'h88, 8'h89, 8'hA8,
		8'hA9, 8'hC8, 8'hC9, 8'h93, 8'hB3, 8'hD3, 8'h11, 8'h31, 8'h12, 8'h13,
		8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F,
		8'hE0, 8'hE1};
	always #12.5 CLOCK = ~CLOCK;
	bit_logic_branch_exec i_bit_logic_branch_exec (.CLOCK(CLOCK), .RSTN(RSTN),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
	// Memory answers after 0 to 2 cycles; idle data toggles every cycle.
	always @(posedge CLOCK) begin
		if (MEM_ACK) begin
			if (MEM_REQ.write) mem[MEM_REQ.addr[7:0]] <= MEM_REQ.wdata;
			MEM_ACK <= 1'b0;
			MEM_RDATA <= ~MEM_RDATA;
		end else if (MEM_REQ.valid === 1'b1 && dly == 0) begin
			MEM_ACK <= 1'b1;
			MEM_RDATA <= mem[MEM_REQ.addr[7:0]];
			dly <= $urandom_range(2);
		end else begin
			dly <= (dly > 0) ? dly - 1 : 0;
			MEM_RDATA <= MEM_RDATA ^ 8'hA5;
		end
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Tasks and expectation helpers.
	// ----------------------------------------------------------------
	task give_verdict;
		$display("Mismatches %0d, comparisons %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
		end
	endtask : chk
	// One APB transfer, entered just after a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		// Waits for the answer; only the bench timeout ends a hang.
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLOCK);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	// Loads all operands, starts the opcode and polls until not busy.
	task automatic run(input logic [7:0] op, input logic m, output logic [31:0] st);
		logic e;
		for (int k = 0; k < 8; k++) wr(8'(4 * (k + 1)), r[k]);
		wr(REG_CTRL, {22'h0, m, 1'b1, op});
		do begin
			apb(1'b0, REG_STATUS, 32'h0, st, e);
		end while (st[0] !== 1'b0);
	endtask : run
	function automatic logic met(logic [7:0] op, logic [3:0] f);
		case (op)
			8'h12: return !f[FLAG_Z];
			8'h13: return f[FLAG_Z];
			8'h14: return !(f[FLAG_N] | f[FLAG_Z]);
			8'h15: return f[FLAG_N] | f[FLAG_Z];
			8'h18: return !f[FLAG_N];
			8'h19: return f[FLAG_N];
			8'h1A: return !(f[FLAG_C] | f[FLAG_Z]);
			8'h1B: return f[FLAG_C] | f[FLAG_Z];
			8'h1C: return !f[FLAG_V];
			8'h1D: return f[FLAG_V];
			8'h1E: return !f[FLAG_C];
			8'h1F: return f[FLAG_C];
			default: return 1'b1;
		endcase
	endfunction : met
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] st, wm, t, ed, ep, es, eb;
		logic [7:0] op, a, nb;
		logic tk;
		void'($urandom(32'h3D80));
		foreach (mem[i]) mem[i] = 8'($urandom);
		repeat (20) @(posedge CLOCK);
		RSTN <= 1'b1;
		@(posedge CLOCK);
		for (int i = 0; i < 10; i++) rd(8'(4 * i), 32'h0, 1'b0);
		rd(8'h28, 32'h0, 1'b1);
		rd(8'hFC, 32'h0, 1'b1);
		// Every opcode except E2 to E7 with random operands; first pass uses a zero mask.
		for (int j = 0; j < 108; j++) begin
			op = OPS[j % 27];
			foreach (r[k]) r[k] = $urandom;
			r[6] = $urandom_range(31);
			if (j < 27) r[0] = 32'h0;
			if (j < 27) r[5] = 32'h0000_8080;
			wm = (op[7:5] == WID_BYTE) ? LOW_BYTE : (op[7:5] == WID_WORD) ?
				LOW_HALF : 32'hFFFF_FFFF;
			{ed, ep, es, tk} = {r[2], r[3], r[4], 1'b0};
			case (op) inside
				8'hB9: es = r[4] & ~(r[0] & LOW_HALF);
				8'hB8: es = r[4] | (r[0] & LOW_HALF);
				8'h88, 8'hA8, 8'hC8: ed = (r[2] & ~wm) | ((r[2] | r[0]) & wm);
				8'h89, 8'hA9, 8'hC9: ed = (r[2] & ~wm) | ((r[1] | r[0]) & wm);
				8'h93, 8'hB3, 8'hD3: begin
					t = r[0] & r[1] & wm;
					es[FLAG_Z] = (t == 32'h0);
					es[FLAG_N] = |(t & ~(wm >> 1));
					es[FLAG_V] = 1'b0;
				end
				8'h31: tk = 1'b1;
				8'hE0, 8'hE1: tk = (r[7][r[6][4:0]] == (op == 8'hE0));
				default: tk = met(op, r[4][3:0]);
			endcase
			// The word jump alone uses the full 16-bit displacement.
			if (tk) ep = r[3] + ((op == 8'h31) ?
				{{16{r[5][15]}}, r[5][15:0]} : {{24{r[5][7]}}, r[5][7:0]});
			run(op, 1'b0, st);
			rd(REG_DST, ed, 1'b0);
			rd(REG_PC, ep, 1'b0);
			rd(REG_STATUS_WORD, es, 1'b0);
			if (op < 8'h80 || op > 8'hDF) chk(st[1], tk);
		end
		// All eight bit branch forms, bit alternately in the base register and in memory.
		for (int j = 0; j < 32; j++) begin
			op = 8'(8'hE0 + (j % 8));
			foreach (r[k]) r[k] = $urandom;
			r[6] = $urandom_range(31);
			if (j[3]) r[7] = $urandom_range(100);
			a = 8'(r[7] + (r[6] >> 3));
			nb = mem[a];
			tk = j[3] ? nb[r[6][2:0]] : r[7][r[6][4:0]];
			// E0, E2, E4 and E6 branch on a one, the others on a zero.
			tk = (tk == (op inside {8'hE0, 8'hE2, 8'hE4, 8'hE6}));
			eb = r[7];
			// E2, E3 and E6 leave the bit set; E4, E5 and E7 clear it.
			if (op > 8'hE1) begin
				nb[r[6][2:0]] = op inside {8'hE2, 8'hE3, 8'hE6};
				if (!j[3]) eb[r[6][4:0]] = nb[r[6][2:0]];
			end
			ep = tk ? r[3] + {{24{r[5][7]}}, r[5][7:0]} : r[3];
			run(op, j[3], st);
			if (j[3]) chk({24'h0, mem[a]}, {24'h0, nb});
			rd(REG_BASE, eb, 1'b0);
			rd(REG_PC, ep, 1'b0);
			chk(st[1], tk);
		end
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
